// *** tods_defs.svh ***
// Register map, field positions and reset values for the timer output delay block.
`ifndef TODS_DEFS_SVH
`define TODS_DEFS_SVH
`define TODS_IDX_DELAY 32'hFFFFF668
`define TODS_IDX_SOFTCAP 32'h0FFFF66A
`define TODS_IDX_LO 9:0
`define TODS_ADDR_WORD 11:2
`define TODS_DELAY_RESET 16'h0000
`define TODS_SOFTCAP_RESET 16'h0000
`define TODS_DELAY_MASK 16'h7777
`define TODS_SOFTCAP_FIRST 1
`define TODS_SOFTCAP_LAST 4
`define TODS_FIELD_STRIDE 4
`define TODS_FIELD_WIDTH 3
`define TODS_MAX_DELAY 7
`define TODS_PINS 4
`endif

// *** tods_pkg.sv ***
// Types shared by the timer output delay and software capture block.
package tods_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tods_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tods_apb_rsp_type;

  typedef struct packed {
    logic [4:1] captureModeSelReg;
    logic [4:1] externalEvent;
    logic [4:1] externalEventEnable;
  } tods_capture_ctl_type;

  typedef enum logic [1:0] {
    APB_IDLE,
    APB_SETUP,
    APB_ACCESS
  } tods_apb_state_type;
endpackage

// *** tods_top.sv ***
// Timer output delay stages and software-triggered capture with an APB register slave.
//
// Functional notes
// - Four per-pin delay stages, each with three-bit field.
// - Zero passes straight; else delay N clocks.
// - Both registers read and written as 16-bit.
// - Delay register accepts byte-lane and bit updates; here bit changes need a read-modify-write of a lane.
// - Writing one triggers capture in capture mode.
// - Capture takes the multiplexed time-base count value.
//
// The implementer's own choice: register access over APB.
`include "tods_defs.svh"

module tods_top (
  input wire logic clock,
  input wire logic rst,
  input wire tods_pkg::tods_apb_req_type apbReq,
  output tods_pkg::tods_apb_rsp_type apbRsp,
  input wire logic [`TODS_PINS-1:0] timerOutRaw,
  output logic [`TODS_PINS-1:0] timerOutputPin,
  input wire tods_pkg::tods_capture_ctl_type captureCtl,
  input wire logic [15:0] muxedCountValue,
  output logic [4:1] captureStrobe,
  output logic [4:1][15:0] captureValue
);
  import tods_pkg::*;

  logic [15:0] outputDelayControl;
  logic [15:0] softwareCaptureTrigger;
  logic [31:0] rdData;
  logic rdErr;
  tods_apb_state_type apbState;
  tods_apb_state_type next_apbState;

  wire setupPhase = apbReq.psel & ~apbReq.penable;
  wire accessPhase = apbReq.psel & apbReq.penable;
  wire [9:0] wordAddr = apbReq.paddr[`TODS_ADDR_WORD];
  // The bus carries only twelve address bits, so only the low ten bits of each
  // register index take part in the decode.
  wire [31:0] delayIndex = `TODS_IDX_DELAY;
  wire [31:0] softCapIndex = `TODS_IDX_SOFTCAP;
  wire hitDelay = (wordAddr == delayIndex[`TODS_IDX_LO]);
  wire hitSoftCap = (wordAddr == softCapIndex[`TODS_IDX_LO]);
  wire hitAny = hitDelay | hitSoftCap;
  // A write lands once, on the first access cycle after a proper setup cycle.
  wire firstAccess = accessPhase & (apbState == APB_SETUP);
  wire wrStrobe = firstAccess & apbReq.pwrite;
  wire wrDelay = wrStrobe & hitDelay;
  wire wrSoftCap = wrStrobe & hitSoftCap;

  // The slave answers with zero wait states; read data was prepared in the setup cycle.
  assign apbRsp.pready = accessPhase;
  assign apbRsp.prdata = rdData;
  assign apbRsp.pslverr = accessPhase & rdErr;

  always_comb begin
    case (apbState)
      APB_IDLE: next_apbState = setupPhase ? APB_SETUP : APB_IDLE;
      APB_SETUP: next_apbState = accessPhase ? APB_ACCESS : APB_IDLE;
      APB_ACCESS: next_apbState = setupPhase ? APB_SETUP : APB_IDLE;
      default: next_apbState = APB_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      apbState <= APB_IDLE;
    end else begin
      apbState <= next_apbState;
    end
  end

  wire [15:0] delayReadValue = outputDelayControl & `TODS_DELAY_MASK;
  wire [15:0] readMux = hitDelay ? delayReadValue :
                        hitSoftCap ? softwareCaptureTrigger : 16'h0000;

  // Read data is latched in the setup cycle so it comes from a flop during access.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= 32'h00000000;
      rdErr <= 1'b0;
    end else if (setupPhase) begin
      rdData <= {16'h0000, readMux};
      rdErr <= ~hitAny;
    end
  end

  // Byte lanes let software update either half on its own; single-bit changes are
  // made by read-modify-write of a lane, which takes a read and then a separate lane write.
  wire [15:0] laneMask = {{8{apbReq.pstrb[1]}}, {8{apbReq.pstrb[0]}}};
  wire [15:0] next_delayValue = ((outputDelayControl & ~laneMask) |
                                 (apbReq.pwdata[15:0] & laneMask)) & `TODS_DELAY_MASK;

  always_ff @(posedge clock) begin
    if (rst) begin
      outputDelayControl <= `TODS_DELAY_RESET;
    end else if (wrDelay) begin
      outputDelayControl <= next_delayValue;
    end
  end

  // Software capture: the register is taken as a whole word, lanes are not used.
  logic [4:1] softPending;
  logic [4:1] captureFire;
  logic [4:1] next_softPending;
  wire [4:1] softWriteOnes = wrSoftCap ?
                             apbReq.pwdata[`TODS_SOFTCAP_LAST:`TODS_SOFTCAP_FIRST] : 4'h0;

  // A pending bit fires only while the sub-channel is in capture-register mode,
  // and external event enables are bypassed for the software trigger.
  assign captureFire = captureCtl.captureModeSelReg &
                       (softPending |
                        (captureCtl.externalEvent & captureCtl.externalEventEnable));

  // A write of one in the same cycle as the automatic clear keeps the bit set,
  // so a second request is never lost. Writing zero leaves a pending bit alone.
  assign next_softPending = (softPending & ~(captureFire & captureCtl.captureModeSelReg)) |
                            softWriteOnes;

  always_ff @(posedge clock) begin
    if (rst) begin
      softPending <= 4'h0;
    end else begin
      softPending <= next_softPending;
    end
  end

  always_comb begin
    softwareCaptureTrigger = `TODS_SOFTCAP_RESET;
    softwareCaptureTrigger[`TODS_SOFTCAP_LAST:`TODS_SOFTCAP_FIRST] = softPending;
  end

  genvar ch;
  generate
    for (ch = `TODS_SOFTCAP_FIRST; ch <= `TODS_SOFTCAP_LAST; ch++) begin : gCapture
      tods_capture_chan #(
        .WIDTH(16)
      ) captureChan (
        .clock(clock),
        .rst(rst),
        .fire(captureFire[ch]),
        .countValue(muxedCountValue),
        .strobe(captureStrobe[ch]),
        .value(captureValue[ch])
      );
    end
  endgenerate

  // Each pin has a seven-deep history; the field picks the tap. Staggering the
  // pin edges spreads switching current, at the cost of up to seven clocks of lag.
  genvar pin;
  generate
    for (pin = 0; pin < `TODS_PINS; pin++) begin : gDelay
      wire [`TODS_FIELD_WIDTH-1:0] delaySel =
        outputDelayControl[pin*`TODS_FIELD_STRIDE +: `TODS_FIELD_WIDTH];

      tods_delay_stage #(
        .DEPTH(`TODS_MAX_DELAY),
        .SEL_WIDTH(`TODS_FIELD_WIDTH)
      ) delayStage (
        .clock(clock),
        .rst(rst),
        .delaySel(delaySel),
        .rawLevel(timerOutRaw[pin]),
        .pinLevel(timerOutputPin[pin])
      );
    end
  endgenerate
endmodule

// One sub-channel's capture register; the strobe marks the cycle the value is new.
module tods_capture_chan #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic [WIDTH-1:0] countValue,
  output logic strobe,
  output logic [WIDTH-1:0] value
);
  always_ff @(posedge clock) begin
    if (rst) begin
      strobe <= 1'b0;
    end else begin
      strobe <= fire;
    end
  end

  // The last capture stands until the next one, so software may read it late.
  always_ff @(posedge clock) begin
    if (rst) begin
      value <= '0;
    end else if (fire) begin
      value <= countValue;
    end
  end
endmodule

// One pin's delay line: a shift register of past levels and a tap chosen by the field.
module tods_delay_stage #(
  parameter int DEPTH = `TODS_MAX_DELAY,
  parameter int SEL_WIDTH = `TODS_FIELD_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [SEL_WIDTH-1:0] delaySel,
  input wire logic rawLevel,
  output logic pinLevel
);
  logic [DEPTH-1:0] history;
  logic [DEPTH-1:0] next_history;

  assign next_history = {history[DEPTH-2:0], rawLevel};

  always_ff @(posedge clock) begin
    if (rst) begin
      history <= '0;
    end else begin
      history <= next_history;
    end
  end

  // A zero field bypasses the chain so the pin follows the compare output directly.
  // No flush on a field change: the history is always full, so the new tap is valid at once.
  assign pinLevel = (delaySel == '0) ? rawLevel : history[delaySel - 1'b1];
endmodule

// *** tods_load.sv ***
// Behavioural load on the four timer output pins.
module tods_load (
  input wire logic clock,
  input wire logic [3:0] pinLevel,
  output logic [3:0] lastLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock) begin
    lastLevel <= pinLevel;
  end
endmodule

// *** tods_chk.sv ***
// Port assertions for the delay and software capture block.
module tods_chk (
  input wire logic clock,
  input wire logic rst,
  input wire tods_pkg::tods_apb_req_type apbReq,
  input wire tods_pkg::tods_apb_rsp_type apbRsp,
  input wire logic [3:0] timerOutRaw,
  input wire logic [3:0] timerOutputPin,
  input wire tods_pkg::tods_capture_ctl_type captureCtl,
  input wire logic [15:0] muxedCountValue,
  input wire logic [4:1] captureStrobe,
  input wire logic [4:1][15:0] captureValue
);
  timeunit 1ns;
  timeprecision 1ns;
  import tods_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = apbReq.psel && apbReq.penable;
  wire hit = apbReq.paddr[11:2] inside {10'h268, 10'h26A};
  wire swr = acc && apbReq.pwrite && apbReq.paddr == 12'h9A8 && apbReq.pwdata[1];
  chk_ready_zero: assert property (apbRsp.pready == acc)
    else $error("pready");
  chk_unmapped_err: assert property (acc |-> apbRsp.pslverr == !hit)
    else $error("pslverr");
  chk_upper_zero: assert property (acc |-> apbRsp.prdata[31:16] == 16'h0000)
    else $error("prdata");
  chk_soft_fire: assert property (swr ##1 captureCtl.captureModeSelReg[1] |=> captureStrobe[1])
    else $error("soft fire");
  chk_mode_gate: assert property (!captureCtl.captureModeSelReg[3] |=> !captureStrobe[3])
    else $error("mode gate");
  chk_capture_value: assert property (captureStrobe[1] |-> captureValue[1] == $past(muxedCountValue))
    else $error("value");
  chk_value_hold: assert property ($changed(captureValue[2]) |-> captureStrobe[2])
    else $error("hold");
  cover property (swr);
  cover property (captureStrobe[2]);
  cover property (acc && !hit);
endmodule

// *** testbench.sv ***
// Self-checking bench for the output delay and software capture block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tods_pkg::*;
  logic clock = 0, rst = 1, err;
  tods_apb_req_type apbReq = '0;
  tods_apb_rsp_type apbRsp;
  logic [3:0] timerOutRaw = 4'h0, timerOutputPin;
  tods_capture_ctl_type captureCtl = '0;
  logic [15:0] muxedCountValue = 16'h1234;
  logic [4:1] captureStrobe;
  logic [4:1][15:0] captureValue;
  logic [31:0] rd;
  int miscompares = 0, tests_run = 0;
  logic [3:0] loadLevel;
  // Each row is a delay register value above the lag in clocks that it should give.
  logic [19:0] rows [8] = '{20'h00000, 20'h11111, 20'h22222, 20'h33333,
    20'h44444, 20'h55555, 20'h66666, 20'h77777};
  always #25 clock = ~clock;
  tods_top DUT (.clock(clock), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .timerOutRaw(timerOutRaw), .timerOutputPin(timerOutputPin), .captureCtl(captureCtl),
    .muxedCountValue(muxedCountValue), .captureStrobe(captureStrobe), .captureValue(captureValue));
  tods_load LOAD (.clock(clock), .pinLevel(timerOutputPin), .lastLevel(loadLevel));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
    input logic [3:0] s);
    @(posedge clock);
    apbReq <= {2'b10, w, a, 16'h0000, d, s};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (apbRsp.pready !== 1'b1) @(posedge clock);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task end_sim;
    $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    apb(0, 12'h9A0, 0, 0);
    chk(rd, 0, "delay reset");
    apb(0, 12'h9A8, 0, 0);
    chk(rd, 0, "capture reset");
    $display("Reset values done");
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h9A0, rows[i][19:4], 4'hF);
      @(posedge clock);
      timerOutRaw <= 4'hF;
      repeat (rows[i][3:0]) begin
        #1 chk(timerOutputPin, 0, "early pin");
        @(posedge clock);
      end
      #1 chk(timerOutputPin, 4'hF, "delayed pin");
      @(posedge clock);
      timerOutRaw <= 4'h0;
      #1 chk(loadLevel, 4'hF, "load level");
      repeat (8) @(posedge clock);
      $display("Delay %0d done", i);
    end
    apb(1, 12'h9A0, 16'h7777, 4'hF);
    apb(1, 12'h9A0, 16'h0000, 4'h1);
    apb(0, 12'h9A0, 0, 0);
    chk(rd, 32'h7700, "byte lane");
    apb(0, 12'h000, 0, 0);
    chk(err, 1, "unmapped");
    captureCtl.captureModeSelReg <= 4'h1;
    apb(1, 12'h9A8, 16'h0006, 4'hF);
    repeat (3) @(posedge clock);
    chk(captureValue[1], 16'h1234, "soft value");
    apb(0, 12'h9A8, 0, 0);
    chk(rd, 4, "pending");
    muxedCountValue <= 16'hBEEF;
    captureCtl.captureModeSelReg <= 4'hF;
    repeat (3) @(posedge clock);
    chk(captureValue[2], 16'hBEEF, "late value");
    apb(0, 12'h9A8, 0, 0);
    chk(rd, 0, "auto clear");
    muxedCountValue <= 16'hC0DE;
    captureCtl.externalEventEnable <= 4'h4;
    captureCtl.externalEvent <= 4'hC;
    @(posedge clock);
    captureCtl.externalEvent <= 4'h0;
    repeat (2) @(posedge clock);
    chk(captureValue[3], 16'hC0DE, "event value");
    chk(captureValue[4], 16'h0000, "event gated");
    $display("Capture tests done");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(0, 12'h9A0, 0, 0);
    chk(rd, 0, "delay after reset");
    chk(captureValue[3], 16'h0000, "value after reset");
    $display("Reset test done");
    end_sim;
  end
  initial begin
    #50000;
    miscompares++;
    end_sim;
  end
endmodule
bind tods_top tods_chk u_chk (.clock(clock), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .timerOutRaw(timerOutRaw), .timerOutputPin(timerOutputPin), .captureCtl(captureCtl),
  .muxedCountValue(muxedCountValue), .captureStrobe(captureStrobe), .captureValue(captureValue));
